// [common/ocp_cfg.svh]
// Overview of operation
// - discharge overcurrent turns discharge switch off unless disabled
// - discharge overcurrent always flags, powers temp sensor
// - discharge overcurrent threshold from two field bits
// - short circuit turns discharge switch off unless disabled
// - short circuit always flags, powers temp sensor
// - short circuit threshold from two field bits
// - discharge delay 128 to 1024 ms by code
// - discharge divide bit divides that delay by 64
// - charge overcurrent turns charge switch off unless disabled
// - charge overcurrent always flags, powers temp sensor
// - charge overcurrent threshold from two field bits
// - short circuit must last 100us, or 8ms
// - charge divide bit divides the charge delay by 32
// - charge delay 64 to 512 ms by code
// - auto-off clears matching switch enable bit
// - discharge setup writes need its write enable
// - charge setup writes need its write enable
`ifndef OCP_CFG_SVH
`define OCP_CFG_SVH

// clock and timebase
`define OCP_CLK_PERIOD_NS   5
`define OCP_TICK_NS         1000
`define OCP_TICK_CYCLES     (`OCP_TICK_NS / `OCP_CLK_PERIOD_NS)
`define OCP_US_PER_MS       1000
`define OCP_TICKW           20

// delay figures
`define OCP_SHORT_FAST_US   100
`define OCP_SHORT_LONG_MS   8
`define OCP_DOC_BASE_MS     128
`define OCP_COC_BASE_MS     64
`define OCP_DOC_DIV_SHIFT   6
`define OCP_COC_DIV_SHIFT   5

// register offsets
`define OCP_STATUS_OFS      8'h0A
`define OCP_FET_OFS         8'h04
`define OCP_DSET_OFS        8'h05
`define OCP_CSET_OFS        8'h06
`define OCP_WREN_OFS        8'h08

// reset values
`define OCP_REG_RESET       8'h00

// switch control fields
`define OCP_FET_CHG_BIT     1
`define OCP_FET_DIS_BIT     0

// discharge setup fields
`define OCP_DSET_DOC_OFF    7
`define OCP_DSET_DOCV_HI    6
`define OCP_DSET_DOCV_LO    5
`define OCP_DSET_SC_OFF     4
`define OCP_DSET_SCV_HI     3
`define OCP_DSET_SCV_LO     2
`define OCP_DSET_DOCT_HI    1
`define OCP_DSET_DOCT_LO    0

// charge and time scale fields
`define OCP_CSET_COC_OFF    7
`define OCP_CSET_COCV_HI    6
`define OCP_CSET_COCV_LO    5
`define OCP_CSET_SC_LONG    4
`define OCP_CSET_CDIV       3
`define OCP_CSET_DDIV       2
`define OCP_CSET_COCT_HI    1
`define OCP_CSET_COCT_LO    0

// write enable fields
`define OCP_WREN_CSET_BIT   6
`define OCP_WREN_DSET_BIT   5

// status fields
`define OCP_ST_DOC_BIT      0
`define OCP_ST_SC_BIT       1
`define OCP_ST_COC_BIT      2

`endif

// [common/ocp_pkg.sv]
package ocp_pkg;

  // delay timer progress
  typedef enum logic [1:0] {
    OCP_TMR_IDLE,
    OCP_TMR_RUN,
    OCP_TMR_DONE
  } ocp_tmr_state_t;

  // delay length in microsecond ticks
  typedef logic [19:0] ocp_ticks_t;

  // one bit per fault source, in status bit order
  typedef logic [2:0] ocp_fault_vec_t;

endpackage : ocp_pkg

// [common/ocp_tick_if.sv]
`timescale 1ns/10ps
interface ocp_tick_if;
  logic tick;  // one-cycle pulse each microsecond

  modport src (output tick);
  modport snk (input tick);
endinterface : ocp_tick_if

// [rtl/ocp_timebase.sv]
`timescale 1ns/10ps
module ocp_timebase #(
  parameter int CYCLES = 200
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  // tick out
  ocp_tick_if.src     tickBus
);
  import ocp_pkg::*;

  // refuse a period the counter cannot make
  if (CYCLES < 1 || CYCLES > 65536) begin : g_bad_cycles
    $error("ocp_timebase: CYCLES out of range");
  end

  logic [15:0] divCnt_r;   // cycles into the current tick period
  logic [15:0] divCnt_nxt;
  logic        tick_r;     // registered tick pulse
  logic        tick_nxt;

  // free-running divider; every delay shares it so they stay in step
  always_comb begin
    tick_nxt   = 1'b0;
    divCnt_nxt = divCnt_r + 16'h0001;
    if (divCnt_r == 16'(CYCLES - 1)) begin
      divCnt_nxt = 16'h0000;
      tick_nxt   = 1'b1;
    end
  end

  // register divider state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt_r <= 16'h0000;
      tick_r   <= 1'b0;
    end else begin
      divCnt_r <= divCnt_nxt;
      tick_r   <= tick_nxt;
    end
  end

  assign tickBus.tick = tick_r;

endmodule : ocp_timebase

// [rtl/ocp_delay_timer.sv]
`timescale 1ns/10ps
module ocp_delay_timer (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // timebase
  ocp_tick_if.snk         tickBus,
  // condition and length
  input  wire logic       active,
  input  ocp_pkg::ocp_ticks_t limit,
  // expiry pulse
  output logic            expired
);
  import ocp_pkg::*;

  ocp_tmr_state_t st_r;     // timer progress
  ocp_tmr_state_t st_nxt;
  ocp_ticks_t     cnt_r;    // elapsed ticks
  ocp_ticks_t     cnt_nxt;
  logic           fire_r;   // one-cycle expiry pulse
  logic           fire_nxt;

  // count ticks while the condition holds; any drop starts over
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    fire_nxt = 1'b0;
    if (!active) begin
      st_nxt  = OCP_TMR_IDLE;
      cnt_nxt = '0;
    end else begin
      unique case (st_r)
        OCP_TMR_IDLE, OCP_TMR_RUN: begin
          st_nxt = OCP_TMR_RUN;
          if (tickBus.tick) begin
            // compare with >= so a shortened limit mid-count still fires
            if (cnt_r + 20'h00001 >= limit) begin
              st_nxt   = OCP_TMR_DONE;
              fire_nxt = 1'b1;
            end else begin
              cnt_nxt = cnt_r + 20'h00001;
            end
          end
        end
        OCP_TMR_DONE: begin
          // fired once; wait for the condition to go away
          st_nxt = OCP_TMR_DONE;
        end
      endcase
    end
  end

  // register timer state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r   <= OCP_TMR_IDLE;
      cnt_r  <= '0;
      fire_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign expired = fire_r;

endmodule : ocp_delay_timer

// [rtl/ocp_protect.sv]
`timescale 1ns/10ps
`include "ocp_cfg.svh"
module ocp_protect #(
  parameter int TICK_CYCLES = `OCP_TICK_CYCLES,  // core cycles per microsecond tick
  parameter int US_PER_MS   = `OCP_US_PER_MS     // ticks per millisecond
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port from the serial front end
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // comparator results, asynchronous
  input  wire logic        dischargeOcSense,
  input  wire logic        chargeOcSense,
  input  wire logic        shortSense,
  // flag clear pulses, status bit order
  input  ocp_pkg::ocp_fault_vec_t flagClear,
  // comparator threshold selects
  output logic [1:0]       ocThresholdVoltage,
  output logic [1:0]       shortThresholdVoltage,
  output logic [1:0]       chargeOcThreshold,
  // power switch drive
  output logic             chargeSwitchEnable,
  output logic             dischargeSwitchEnable,
  // fault flags and sensor supply
  output logic             dischargeOcFlag,
  output logic             shortFaultFlag,
  output logic             chargeOcFlag,
  output logic             tempSensorSupplyOut
);
  import ocp_pkg::*;

  // refuse figures the timers cannot hold
  if (TICK_CYCLES < 1 || US_PER_MS < 1 || US_PER_MS > 1000) begin : g_bad_params
    $error("ocp_protect: timing parameters out of range");
  end

  // delay bases in ticks
  localparam int DocBaseTicks   = `OCP_DOC_BASE_MS * US_PER_MS;
  localparam int CocBaseTicks   = `OCP_COC_BASE_MS * US_PER_MS;
  localparam int ShortFastTicks = `OCP_SHORT_FAST_US;
  localparam int ShortLongTicks = `OCP_SHORT_LONG_MS * US_PER_MS;

  // scale a base delay by its code, then optionally divide by a power of two
  function automatic ocp_ticks_t ocpDelayTicks(
    input logic [1:0] code,
    input logic       divOn,
    input ocp_ticks_t baseTicks,
    input logic [2:0] divShift
  );
    ocp_ticks_t full;
    full = baseTicks << code;
    return divOn ? (full >> divShift) : full;
  endfunction : ocpDelayTicks

  // setup registers
  logic [7:0]     dset_r;      // discharge protect setup
  logic [7:0]     dset_nxt;
  logic [7:0]     cset_r;      // charge and time scale setup
  logic [7:0]     cset_nxt;
  logic           dsetWe_r;    // discharge setup write enable
  logic           dsetWe_nxt;
  logic           csetWe_r;    // charge setup write enable
  logic           csetWe_nxt;
  logic           chgSw_r;     // charge switch enable bit
  logic           chgSw_nxt;
  logic           disSw_r;     // discharge switch enable bit
  logic           disSw_nxt;
  ocp_fault_vec_t flag_r;      // sticky fault flags
  ocp_fault_vec_t flag_nxt;
  logic           tempOn_r;    // sensor supply request
  logic           tempOn_nxt;
  logic [7:0]     rd_r;        // read data
  logic [7:0]     rd_nxt;

  // input synchronisers
  logic [2:0]     senseMeta_r; // first stage, read only by the second
  logic [2:0]     senseSync_r; // safe to use
  logic [2:0]     senseMeta_nxt;
  logic [2:0]     senseSync_nxt;

  // timer plumbing
  ocp_ticks_t     docLimit;    // discharge overcurrent delay
  ocp_ticks_t     cocLimit;    // charge overcurrent delay
  ocp_ticks_t     scLimit;     // short circuit delay
  logic           docHit;      // discharge overcurrent confirmed
  logic           cocHit;      // charge overcurrent confirmed
  logic           scHit;       // short circuit confirmed
  logic           disOff;      // automatic discharge switch off
  logic           chgOff;      // automatic charge switch off

  ocp_tick_if tickBus ();

  // shared microsecond tick
  ocp_timebase #(
    .CYCLES (TICK_CYCLES)
  ) u_timebase (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tickBus  (tickBus.src)
  );

  // two flops on each comparator line; they are analog and free running
  always_comb begin
    senseMeta_nxt = {chargeOcSense, shortSense, dischargeOcSense};
    senseSync_nxt = senseMeta_r;
  end

  // register synchroniser stages
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      senseMeta_r <= 3'h0;
      senseSync_r <= 3'h0;
    end else begin
      senseMeta_r <= senseMeta_nxt;
      senseSync_r <= senseSync_nxt;
    end
  end

  // delay lengths from the live setup fields
  always_comb begin
    docLimit = ocpDelayTicks(dset_r[`OCP_DSET_DOCT_HI:`OCP_DSET_DOCT_LO],
                             cset_r[`OCP_CSET_DDIV],
                             20'(DocBaseTicks), 3'(`OCP_DOC_DIV_SHIFT));
    cocLimit = ocpDelayTicks(cset_r[`OCP_CSET_COCT_HI:`OCP_CSET_COCT_LO],
                             cset_r[`OCP_CSET_CDIV],
                             20'(CocBaseTicks), 3'(`OCP_COC_DIV_SHIFT));
    // the long setting trades fast shutdown for immunity to inrush
    scLimit  = cset_r[`OCP_CSET_SC_LONG] ? 20'(ShortLongTicks)
                                         : 20'(ShortFastTicks);
  end

  // discharge overcurrent delay
  ocp_delay_timer u_doc_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tickBus  (tickBus.snk),
    .active   (senseSync_r[`OCP_ST_DOC_BIT]),
    .limit    (docLimit),
    .expired  (docHit)
  );

  // short circuit delay
  ocp_delay_timer u_sc_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tickBus  (tickBus.snk),
    .active   (senseSync_r[`OCP_ST_SC_BIT]),
    .limit    (scLimit),
    .expired  (scHit)
  );

  // charge overcurrent delay
  ocp_delay_timer u_coc_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tickBus  (tickBus.snk),
    .active   (senseSync_r[`OCP_ST_COC_BIT]),
    .limit    (cocLimit),
    .expired  (cocHit)
  );

  // automatic turn-off requests, gated by the disable bits
  always_comb begin
    disOff = (docHit && !dset_r[`OCP_DSET_DOC_OFF])
          || (scHit  && !dset_r[`OCP_DSET_SC_OFF]);
    chgOff = cocHit && !cset_r[`OCP_CSET_COC_OFF];
  end

  // register writes, switch control, flags and read data
  always_comb begin
    dset_nxt   = dset_r;
    cset_nxt   = cset_r;
    dsetWe_nxt = dsetWe_r;
    csetWe_nxt = csetWe_r;
    chgSw_nxt  = chgSw_r;
    disSw_nxt  = disSw_r;
    rd_nxt     = rd_r;

    if (regWrEn) begin
      unique case (regAddr)
        `OCP_FET_OFS: begin
          chgSw_nxt = regWrData[`OCP_FET_CHG_BIT];
          disSw_nxt = regWrData[`OCP_FET_DIS_BIT];
        end
        `OCP_DSET_OFS: begin
          // locked writes vanish silently
          if (dsetWe_r) begin
            dset_nxt = regWrData;
          end
        end
        `OCP_CSET_OFS: begin
          if (csetWe_r) begin
            cset_nxt = regWrData;
          end
        end
        `OCP_WREN_OFS: begin
          csetWe_nxt = regWrData[`OCP_WREN_CSET_BIT];
          dsetWe_nxt = regWrData[`OCP_WREN_DSET_BIT];
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end

    // protection beats a host turn-on in the same cycle
    if (chgOff) begin
      chgSw_nxt = 1'b0;
    end
    if (disOff) begin
      disSw_nxt = 1'b0;
    end

    // sticky flags: a fault in the clear cycle survives the clear
    flag_nxt = flag_r & ~flagClear;
    flag_nxt[`OCP_ST_DOC_BIT] = flag_nxt[`OCP_ST_DOC_BIT] | docHit;
    flag_nxt[`OCP_ST_SC_BIT]  = flag_nxt[`OCP_ST_SC_BIT]  | scHit;
    flag_nxt[`OCP_ST_COC_BIT] = flag_nxt[`OCP_ST_COC_BIT] | cocHit;

    // sensor supply follows any raised flag
    tempOn_nxt = |flag_nxt;

    // read data answers one cycle after the strobe
    if (regRdEn) begin
      unique case (regAddr)
        `OCP_FET_OFS:    rd_nxt = {6'h00, chgSw_r, disSw_r};
        `OCP_DSET_OFS:   rd_nxt = dset_r;
        `OCP_CSET_OFS:   rd_nxt = cset_r;
        `OCP_WREN_OFS:   rd_nxt = {1'b0, csetWe_r, dsetWe_r, 5'h00};
        `OCP_STATUS_OFS: rd_nxt = {5'h00, flag_r};
        default:         rd_nxt = 8'h00;
      endcase
    end
  end

  // register control state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dset_r   <= `OCP_REG_RESET;
      cset_r   <= `OCP_REG_RESET;
      dsetWe_r <= 1'b0;
      csetWe_r <= 1'b0;
      chgSw_r  <= 1'b0;
      disSw_r  <= 1'b0;
      flag_r   <= 3'h0;
      tempOn_r <= 1'b0;
      rd_r     <= 8'h00;
    end else begin
      dset_r   <= dset_nxt;
      cset_r   <= cset_nxt;
      dsetWe_r <= dsetWe_nxt;
      csetWe_r <= csetWe_nxt;
      chgSw_r  <= chgSw_nxt;
      disSw_r  <= disSw_nxt;
      flag_r   <= flag_nxt;
      tempOn_r <= tempOn_nxt;
      rd_r     <= rd_nxt;
    end
  end

  // outputs straight from flops
  assign regRdData             = rd_r;
  assign ocThresholdVoltage    = dset_r[`OCP_DSET_DOCV_HI:`OCP_DSET_DOCV_LO];
  assign shortThresholdVoltage = dset_r[`OCP_DSET_SCV_HI:`OCP_DSET_SCV_LO];
  assign chargeOcThreshold     = cset_r[`OCP_CSET_COCV_HI:`OCP_CSET_COCV_LO];
  assign chargeSwitchEnable    = chgSw_r;
  assign dischargeSwitchEnable = disSw_r;
  assign dischargeOcFlag       = flag_r[`OCP_ST_DOC_BIT];
  assign shortFaultFlag        = flag_r[`OCP_ST_SC_BIT];
  assign chargeOcFlag          = flag_r[`OCP_ST_COC_BIT];
  assign tempSensorSupplyOut   = tempOn_r;

endmodule : ocp_protect

// [test/ocp_protect_monitor.sv]
`timescale 1ns/10ps
module ocp_protect_monitor #(
  parameter int TICK_CYCLES = 200,  // core cycles per tick
  parameter int US_PER_MS   = 1000  // ticks per millisecond
) (
  // clock and reset
  input wire logic          core_clk,
  input wire logic          rst_n,
  // register port
  input wire logic          regWrEn,
  input wire logic          regRdEn,
  input wire logic [7:0]    regAddr,
  input wire logic [7:0]    regWrData,
  input wire logic [7:0]    regRdData,
  // sense inputs and flag clears
  input wire logic          dischargeOcSense,
  input wire logic          chargeOcSense,
  input wire logic          shortSense,
  input ocp_pkg::ocp_fault_vec_t flagClear,
  // watched outputs
  input wire logic [1:0]    ocThresholdVoltage,
  input wire logic [1:0]    shortThresholdVoltage,
  input wire logic [1:0]    chargeOcThreshold,
  input wire logic          chargeSwitchEnable,
  input wire logic          dischargeSwitchEnable,
  input wire logic          dischargeOcFlag,
  input wire logic          shortFaultFlag,
  input wire logic          chargeOcFlag,
  input wire logic          tempSensorSupplyOut
);
  import ocp_pkg::*;
  logic [7:0] dset_r, dset_nxt;    // shadow of discharge setup
  logic [7:0] cset_r, cset_nxt;    // shadow of charge setup
  logic       weDis_r, weDis_nxt;  // shadow write enables
  logic       weChg_r, weChg_nxt;
  int         scRun_r, scRun_nxt;  // cycles of unbroken short sense
  int         scNeed;              // least run before a short may fire
  // shadow follows only writes that the enables let through
  always_comb begin
    dset_nxt = dset_r;
    cset_nxt = cset_r;
    weDis_nxt = weDis_r;
    weChg_nxt = weChg_r;
    if (regWrEn && regAddr == 8'h08) begin
      weDis_nxt = regWrData[5];
      weChg_nxt = regWrData[6];
    end
    if (regWrEn && regAddr == 8'h05 && weDis_r) dset_nxt = regWrData;
    if (regWrEn && regAddr == 8'h06 && weChg_r) cset_nxt = regWrData;
    scRun_nxt = shortSense ? scRun_r + 1 : 0;
    // a tick may land at once, so one tick of slack is allowed
    scNeed = cset_r[4] ? (8 * US_PER_MS - 1) * TICK_CYCLES : 99 * TICK_CYCLES;
  end
  // register the shadow state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dset_r <= 8'h00;
      cset_r <= 8'h00;
      weDis_r <= 1'b0;
      weChg_r <= 1'b0;
      scRun_r <= 0;
    end else begin
      dset_r <= dset_nxt;
      cset_r <= cset_nxt;
      weDis_r <= weDis_nxt;
      weChg_r <= weChg_nxt;
      scRun_r <= scRun_nxt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_THR_DOC: assert property (ocThresholdVoltage == dset_r[6:5])
    else $error("discharge threshold select differs from setup");
  AST_THR_SC: assert property (shortThresholdVoltage == dset_r[3:2])
    else $error("short threshold select differs from setup");
  AST_THR_COC: assert property (chargeOcThreshold == cset_r[6:5])
    else $error("charge threshold select differs from setup");
  AST_TEMP: assert property (tempSensorSupplyOut == (dischargeOcFlag | shortFaultFlag | chargeOcFlag))
    else $error("sensor supply does not follow the flags");
  AST_DOC_OFF: assert property ($rose(dischargeOcFlag) && !dset_r[7] |-> !dischargeSwitchEnable)
    else $error("discharge switch left on after overcurrent");
  AST_DOC_KEEP: assert property ($rose(dischargeOcFlag) && dset_r[7] && !$rose(shortFaultFlag) && $past(dischargeSwitchEnable) && !$past(regWrEn) |-> dischargeSwitchEnable)
    else $error("discharge switch dropped while auto-off disabled");
  AST_SC_OFF: assert property ($rose(shortFaultFlag) && !dset_r[4] |-> !dischargeSwitchEnable)
    else $error("discharge switch left on after short");
  AST_COC_OFF: assert property ($rose(chargeOcFlag) && !cset_r[7] |-> !chargeSwitchEnable)
    else $error("charge switch left on after overcurrent");
  AST_SC_RUN: assert property ($rose(shortFaultFlag) |-> scRun_r >= scNeed)
    else $error("short flagged before the full delay");
  AST_STICKY: assert property ($fell(dischargeOcFlag) |-> $past(flagClear[0]))
    else $error("discharge flag dropped without a clear");
  COV_DOC: cover property ($rose(dischargeOcFlag));
  COV_SC: cover property ($rose(shortFaultFlag));
  COV_COC: cover property ($rose(chargeOcFlag));
endmodule : ocp_protect_monitor

// [test/ocp_host_model.sv]
`timescale 1ns/10ps
module ocp_host_model (
  // clock
  input  wire logic       core_clk,
  // register port toward the block
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);
  // quiet bus at time zero
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // one write strobe; released lines show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  // read strobe, data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge core_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
  // open both setup registers before any setup write
  task automatic unlock();
    wr(8'h08, 8'h60);
  endtask : unlock
endmodule : ocp_host_model

// [test/ocp_protect_bench.sv]
`timescale 1ns/10ps
module ocp_protect_bench;
  import ocp_pkg::*;
  localparam int TC  = 2;  // shortened tick
  localparam int UPM = 2;  // shortened millisecond
  logic core_clk, rst_n, regWrEn, regRdEn;  // clock, reset, strobes
  logic [7:0] regAddr, regWrData, regRdData, rdVal;
  logic [2:0] sense;       // bit0 discharge oc, bit1 short, bit2 charge oc
  ocp_fault_vec_t flagClear;
  logic [1:0] docThr, scThr, cocThr;
  logic chgSw, disSw, tempOut;
  logic [2:0] flags;       // status bit order
  int miscompares, totalChecks, cycles;
  ocp_protect #(.TICK_CYCLES(TC), .US_PER_MS(UPM)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .dischargeOcSense(sense[0]), .chargeOcSense(sense[2]), .shortSense(sense[1]),
    .flagClear(flagClear), .ocThresholdVoltage(docThr),
    .shortThresholdVoltage(scThr), .chargeOcThreshold(cocThr),
    .chargeSwitchEnable(chgSw), .dischargeSwitchEnable(disSw),
    .dischargeOcFlag(flags[0]), .shortFaultFlag(flags[1]),
    .chargeOcFlag(flags[2]), .tempSensorSupplyOut(tempOut));
  ocp_host_model host (
    .core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
  // free-running 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard sized well above the longest scenario
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      testDone();
    end
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic testDone();
    $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : testDone
  // raise one source, check timing, flag, status, supply and switches
  task automatic fire(input int src, input int ticks, input logic off);
    int n;
    logic [7:0] sw;
    sw = off ? ((src == 2) ? 8'h01 : 8'h02) : 8'h03;
    host.wr(8'h04, 8'h03);
    @(negedge core_clk);
    sense[src] = 1'b1;
    repeat ((ticks - 1) * TC) @(negedge core_clk);
    chk(8'h00, {5'h00, flags});
    n = 0;
    while (flags[src] !== 1'b1 && n < 2 * TC + 8) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'h01 << src, {5'h00, flags});
    chk(8'h01, {7'h00, tempOut});
    chk(sw, {6'h00, chgSw, disSw});
    host.rd(8'h0A, rdVal);
    chk(8'h01 << src, rdVal);
    // the switch register must read back what auto-off left behind
    host.rd(8'h04, rdVal);
    chk(sw, rdVal);
    sense[src] = 1'b0;
    flagClear[src] = 1'b1;
    @(negedge core_clk);
    flagClear = 3'h0;
    @(negedge core_clk);
    chk(8'h00, {4'h0, tempOut, flags});
  endtask : fire
  // reset values, an unmapped place among them
  task automatic t_reset();
    logic [7:0] adr [6] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h0A, 8'h3C};
    foreach (adr[i]) begin
      host.rd(adr[i], rdVal);
      chk(8'h00, rdVal);
    end
  endtask : t_reset
  // setup writes before unlocking are dropped
  task automatic t_refuse();
    host.wr(8'h05, 8'hFF);
    host.wr(8'h06, 8'hFF);
    host.rd(8'h05, rdVal);
    chk(8'h00, rdVal);
    host.rd(8'h06, rdVal);
    chk(8'h00, rdVal);
  endtask : t_refuse
  // every threshold code reaches its select outputs
  task automatic t_thresh();
    host.unlock();
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h05, {1'b0, c[1:0], 1'b0, c[1:0], 2'h0});
      host.wr(8'h06, {1'b0, c[1:0], 5'h00});
      chk({4'h0, c[1:0], c[1:0]}, {4'h0, docThr, scThr});
      chk({6'h00, c[1:0]}, {6'h00, cocThr});
    end
  endtask : t_thresh
  // all discharge delay codes, plain and divided, then auto-off disabled
  task automatic t_doc();
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 4; c++) begin
        host.wr(8'h06, d[0] ? 8'h04 : 8'h00);
        host.wr(8'h05, {6'h00, c[1:0]});
        fire(0, (128 * UPM << c) >> (d * 6), 1'b1);
      end
    end
    host.wr(8'h05, 8'h80);
    fire(0, 4, 1'b0);
  endtask : t_doc
  // all charge delay codes, plain and divided, then auto-off disabled
  task automatic t_coc();
    host.wr(8'h05, 8'h00);
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 4; c++) begin
        host.wr(8'h06, {4'h0, d[0], 1'b0, c[1:0]});
        fire(2, (64 * UPM << c) >> (d * 5), 1'b1);
      end
    end
    host.wr(8'h06, 8'h88);
    fire(2, 4, 1'b0);
  endtask : t_coc
  // both short delays and the auto-off disable
  task automatic t_short();
    host.wr(8'h06, 8'h00);
    host.wr(8'h05, 8'h00);
    fire(1, 100, 1'b1);
    host.wr(8'h06, 8'h10);
    fire(1, 8 * UPM, 1'b1);
    host.wr(8'h05, 8'h10);
    fire(1, 8 * UPM, 1'b0);
  endtask : t_short
  // a short that drops early must not count toward the next one
  task automatic t_restart();
    host.wr(8'h06, 8'h00);
    @(negedge core_clk);
    sense[1] = 1'b1;
    repeat (60 * TC) @(negedge core_clk);
    sense[1] = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(8'h00, {5'h00, flags});
    fire(1, 100, 1'b0);
  endtask : t_restart
  // main sequence
  initial begin
    miscompares = 0;
    totalChecks = 0;
    cycles = 0;
    rst_n = 1'b0;
    sense = 3'h0;
    flagClear = 3'h0;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_refuse();
    t_thresh();
    t_doc();
    t_coc();
    t_short();
    t_restart();
    testDone();
  end
endmodule : ocp_protect_bench
bind ocp_protect ocp_protect_monitor #(.TICK_CYCLES(TICK_CYCLES), .US_PER_MS(US_PER_MS)) mon (
  .core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
  .dischargeOcSense(dischargeOcSense), .chargeOcSense(chargeOcSense),
  .shortSense(shortSense), .flagClear(flagClear),
  .ocThresholdVoltage(ocThresholdVoltage), .shortThresholdVoltage(shortThresholdVoltage),
  .chargeOcThreshold(chargeOcThreshold), .chargeSwitchEnable(chargeSwitchEnable),
  .dischargeSwitchEnable(dischargeSwitchEnable), .dischargeOcFlag(dischargeOcFlag),
  .shortFaultFlag(shortFaultFlag), .chargeOcFlag(chargeOcFlag),
  .tempSensorSupplyOut(tempSensorSupplyOut));
